// >>> src/sei_intr.sv
// sei_intr: serial-side event flags and the interrupt pin
// assumes fifo levels, word strobes and length words arrive on mclk;
// chip select and serial clock are pins and are synchronised here
`timescale 1ns/10ps
`default_nettype none
module sei_intr (
  input wire logic mclk, // system clock, 20 MHz
  input wire logic rst, // async reset, high
  input wire logic spi_csn, // chip select pin, low active
  input wire logic spi_sck, // serial clock pin
  input wire sei_pkg::sei_cmd_s cmd, // decoded command, start is a pulse
  input wire logic tx_fifo_wr, // one word written to tx fifo
  input wire logic rx_fifo_rd, // one word read from rx fifo
  input wire sei_pkg::sei_lvl_s lvl, // fifo levels
  input wire sei_pkg::sei_lim_s lim, // programmed limits
  input wire logic tx_flen_vld, // tx length word present
  input wire logic [31:0] tx_flen_word, // tx length and check
  input wire logic rx_flen_vld, // rx length word present
  input wire logic [31:0] rx_flen_word, // rx length and check
  input wire logic stat_deadlock, // status deadlock pulse
  input wire logic mac_irq, // mac interrupt level
  input wire logic phy_irq, // phy interrupt level
  input wire sei_pkg::sei_flag_t flag_mask, // 1 keeps a flag off the pin
  input wire sei_pkg::sei_flag_t flag_clr, // 1 clears a flag, pulse
  output var sei_pkg::sei_flag_t flag_stat, // pending flags
  output logic irq_out // interrupt pin, high active
);
  import sei_pkg::*;

  typedef struct packed {
    sei_flag_t flags;
    logic irq;
    sei_xfer_e xfer;
    logic [LEN_W-1:0] tx_cnt;
    logic [LEN_W-1:0] rx_cnt;
    logic [TO_W-1:0] idle_cnt;
    logic [EDGE_W-1:0] xtra;
    logic csn_d;
    logic sck_d;
  } sei_state_s;

  sei_state_s st_r;
  sei_state_s st_nxt;

  logic [1:0] pin_s;
  logic csn_s;
  logic sck_s;
  logic csn_rise;
  logic sck_rise;
  logic [15:0] tx_crc;
  logic [15:0] rx_crc;
  logic tx_crc_bad;
  logic rx_crc_bad;
  sei_flag_t set;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection on the synchronised levels
  sei_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({spi_csn, spi_sck}),
    .q(pin_s)
  );

  assign csn_s = pin_s[1];
  assign sck_s = pin_s[0];
  assign csn_rise = csn_s & ~st_r.csn_d;
  assign sck_rise = sck_s & ~st_r.sck_d;

  ////////////////////////////////////////////////////////////////////
  // length word checks on both paths
  sei_crc16 u_tx_crc (
    .data(tx_flen_word[FLEN_LSB +: 16]),
    .crc(tx_crc)
  );

  sei_crc16 u_rx_crc (
    .data(rx_flen_word[FLEN_LSB +: 16]),
    .crc(rx_crc)
  );

  // mismatch against the carried value
  assign tx_crc_bad = tx_flen_vld && (tx_crc != tx_flen_word[FCRC_LSB +: 16]);
  assign rx_crc_bad = rx_flen_vld && (rx_crc != rx_flen_word[FCRC_LSB +: 16]);

  ////////////////////////////////////////////////////////////////////
  // event sources gathered into one set vector
  always_comb
  begin
    set = FLAGS_RST;
    set[F_RX_FRM] = lvl.rx_frames >= lim.rx_frame_count_limit;
    set[F_RX_FILL] = lvl.rx_fill >= lim.rx_fill_limit;
    set[F_RX_TO] = st_r.idle_cnt > lim.rx_idle_timeout_limit;
    set[F_TX_SPACE] = lvl.tx_empty >= lim.tx_space_limit;
    set[F_TS_FILL] = lvl.tx_stat_fill >= lim.tx_status_fill_limit;
    // extra data after the count ran out; combined command never counts
    set[F_TX_SHORT] = (st_r.xfer == ST_WR) && (st_r.tx_cnt == LEN_RST)
      && (tx_fifo_wr || (st_r.xtra >= XTRA_EDGES));
    set[F_TX_LONG] = csn_rise && (st_r.tx_cnt != LEN_RST)
      && (st_r.xfer == ST_WR || st_r.xfer == ST_RW);
    set[F_RX_LONG] = csn_rise && (st_r.rx_cnt != LEN_RST)
      && (st_r.xfer == ST_RD || st_r.xfer == ST_RW);
    set[F_TX_OVR] = tx_fifo_wr && (lvl.tx_empty == '0);
    set[F_RX_UNDR] = rx_fifo_rd && (lvl.rx_fill == '0);
    set[F_TX_CRC] = tx_crc_bad;
    set[F_RX_CRC] = rx_crc_bad;
    set[F_DEAD] = stat_deadlock;
    set[F_MAC] = mac_irq;
    set[F_PHY] = phy_irq;
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.csn_d = csn_s;
    st_nxt.sck_d = sck_s;

    // transfer tracking: counters load word counts at command start
    if (cmd.start)
    begin
      st_nxt.xtra = '0;
      st_nxt.tx_cnt = LEN_RST;
      st_nxt.rx_cnt = LEN_RST;
      unique case (cmd.code)
        CMD_TX_WR:
        begin
          st_nxt.xfer = ST_WR;
          st_nxt.tx_cnt = cmd.tx_len;
        end
        CMD_RX_RD:
        begin
          st_nxt.xfer = ST_RD;
          st_nxt.rx_cnt = cmd.rx_len;
        end
        CMD_FIFO_RW:
        begin
          st_nxt.xfer = ST_RW;
          st_nxt.tx_cnt = cmd.tx_len;
          st_nxt.rx_cnt = cmd.rx_len;
        end
        default:
        begin
          st_nxt.xfer = ST_IDLE;
        end
      endcase
    end
    else if (csn_rise)
    begin
      st_nxt.xfer = ST_IDLE;
      st_nxt.tx_cnt = LEN_RST;
      st_nxt.rx_cnt = LEN_RST;
      st_nxt.xtra = '0;
    end
    else
    begin
      // word strobes count the declared length down
      if (tx_fifo_wr && st_r.tx_cnt != LEN_RST)
      begin
        st_nxt.tx_cnt = st_r.tx_cnt - 12'h001;
      end
      if (rx_fifo_rd && st_r.rx_cnt != LEN_RST)
      begin
        st_nxt.rx_cnt = st_r.rx_cnt - 12'h001;
      end
      // serial clock edges seen once the write count is exhausted
      if (st_r.xfer == ST_WR && st_r.tx_cnt == LEN_RST && sck_rise && !csn_s
          && st_r.xtra != XTRA_EDGES)
      begin
        st_nxt.xtra = st_r.xtra + 4'h1;
      end
    end

    // idle counter: unread non-empty cycles, saturating
    if (rx_fifo_rd || lvl.rx_fill == '0)
    begin
      st_nxt.idle_cnt = IDLE_RST;
    end
    else if (st_r.idle_cnt != '1)
    begin
      st_nxt.idle_cnt = st_r.idle_cnt + 16'h0001;
    end

    // sticky flags: a set in the clearing cycle wins
    st_nxt.flags = (st_r.flags & ~flag_clr) | set;
    // pin follows the unmasked pending flags
    st_nxt.irq = |(st_nxt.flags & ~flag_mask);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r.flags <= FLAGS_RST;
      st_r.irq <= 1'b0;
      st_r.xfer <= ST_IDLE;
      st_r.tx_cnt <= LEN_RST;
      st_r.rx_cnt <= LEN_RST;
      st_r.idle_cnt <= IDLE_RST;
      st_r.xtra <= '0;
      st_r.csn_d <= 1'b1;
      st_r.sck_d <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign flag_stat = st_r.flags;
  assign irq_out = st_r.irq;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_IRQ_PIN: assert property (
    irq_out |-> |(flag_stat & ~$past(flag_mask)))
    else $error("interrupt pin high with no unmasked flag");

  AST_IRQ_RAISE: assert property (
    (|(flag_stat & ~flag_mask) && !(|flag_clr)) |=> irq_out)
    else $error("unmasked pending flag did not raise the pin");

  AST_STICKY: assert property (
    ((($past(flag_stat) & ~$past(flag_clr)) & ~flag_stat) == '0))
    else $error("pending flag dropped without a clear");

  AST_FRAMES: assert property (
    (lvl.rx_frames >= lim.rx_frame_count_limit) |=> flag_stat[F_RX_FRM])
    else $error("frame count flag missed");

  AST_FILL: assert property (
    (lvl.rx_fill >= lim.rx_fill_limit) |=> flag_stat[F_RX_FILL])
    else $error("receive fill flag missed");

  AST_SPACE: assert property (
    (lvl.tx_empty >= lim.tx_space_limit) |=> flag_stat[F_TX_SPACE])
    else $error("transmit space flag missed");

  AST_TSTAT: assert property (
    (lvl.tx_stat_fill >= lim.tx_status_fill_limit) |=> flag_stat[F_TS_FILL])
    else $error("transmit status flag missed");

  AST_IDLE_CLR: assert property (
    (rx_fifo_rd || lvl.rx_fill == '0) |=> (st_r.idle_cnt == IDLE_RST))
    else $error("idle counter not cleared");

  AST_IDLE_CNT: assert property (
    (!rx_fifo_rd && lvl.rx_fill != '0 && st_r.idle_cnt != '1)
      |=> (st_r.idle_cnt == $past(st_r.idle_cnt) + 16'h0001))
    else $error("idle counter did not advance");

  AST_TIMEOUT: assert property (
    (st_r.idle_cnt > lim.rx_idle_timeout_limit) |=> flag_stat[F_RX_TO])
    else $error("timeout flag missed");

  AST_NO_SHORT_RW: assert property (
    (st_r.xfer == ST_RW && !flag_stat[F_TX_SHORT] && !(|flag_clr))
      ##1 (st_r.xfer == ST_RW) |-> !flag_stat[F_TX_SHORT])
    else $error("short flag raised in combined command");

  AST_SHORT: assert property (
    (st_r.xfer == ST_WR && st_r.tx_cnt == LEN_RST && tx_fifo_wr) |=> flag_stat[F_TX_SHORT])
    else $error("write length short flag missed");

  AST_PHY: assert property (
    phy_irq |=> flag_stat[F_PHY])
    else $error("phy source flag missed");

  AST_TX_LONG: assert property (
    (csn_rise && st_r.xfer == ST_WR && st_r.tx_cnt != LEN_RST) |=> flag_stat[F_TX_LONG])
    else $error("write length long flag missed");

  AST_RX_LONG: assert property (
    (csn_rise && st_r.xfer == ST_RD && st_r.rx_cnt != LEN_RST) |=> flag_stat[F_RX_LONG])
    else $error("read length long flag missed");

  AST_OVR: assert property (
    (tx_fifo_wr && lvl.tx_empty == '0) |=> flag_stat[F_TX_OVR])
    else $error("overrun flag missed");

  AST_UNDR: assert property (
    (rx_fifo_rd && lvl.rx_fill == '0) |=> flag_stat[F_RX_UNDR])
    else $error("underrun flag missed");

  AST_TX_CRC: assert property (
    tx_crc_bad |=> flag_stat[F_TX_CRC])
    else $error("tx length check flag missed");

  AST_RX_CRC: assert property (
    rx_crc_bad |=> flag_stat[F_RX_CRC])
    else $error("rx length check flag missed");

  AST_DEAD: assert property (
    stat_deadlock |=> flag_stat[F_DEAD] ##1 (flag_stat[F_DEAD] || $past(flag_clr[F_DEAD])))
    else $error("deadlock flag missed or dropped");

  AST_LOAD: assert property (
    (cmd.start && cmd.code == CMD_FIFO_RW) |=> (st_r.xfer == ST_RW
      && st_r.tx_cnt == $past(cmd.tx_len) && st_r.rx_cnt == $past(cmd.rx_len)))
    else $error("combined command did not load both counters");

  CV_IRQ: cover property ($rose(irq_out));
  CV_SHORT: cover property ($rose(flag_stat[F_TX_SHORT]));
  CV_LONG: cover property ($rose(flag_stat[F_TX_LONG]));
  CV_TIMEOUT: cover property ($rose(flag_stat[F_RX_TO]));
  CV_XTRA: cover property (st_r.xtra == XTRA_EDGES);
endmodule : sei_intr
`default_nettype wire

// >>> src/sei_pkg.sv
// sei_pkg: widths, flag layout, command codes and carrier types
// for the serial-side event interrupt block
// assumes one system clock; no bus, all control bits are plain ports
package sei_pkg;
  // level and count widths
  localparam int RX_LVL_W = 11;
  localparam int TX_LVL_W = 10;
  localparam int TS_LVL_W = 6;
  localparam int FRM_W = 8;
  localparam int TO_W = 16;
  localparam int LEN_W = 12;
  localparam int EDGE_W = 4;
  // command codes of the fifo transfer commands
  localparam logic [3:0] CMD_TX_WR = 4'h4;
  localparam logic [3:0] CMD_RX_RD = 4'h5;
  localparam logic [3:0] CMD_FIFO_RW = 4'h6;
  // frame length check: 16-bit crc, generator 17'h18005 without its top bit
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // length word layout: length low half, check value high half
  localparam int FLEN_LSB = 0;
  localparam int FCRC_LSB = 16;
  // sck edges after the count hits zero that prove extra data (8 + sync slack)
  localparam logic [EDGE_W-1:0] XTRA_EDGES = 4'h9;
  // flag bit positions
  localparam int NFLAG = 15;
  localparam int F_RX_FRM = 0;
  localparam int F_RX_FILL = 1;
  localparam int F_RX_TO = 2;
  localparam int F_TX_SPACE = 3;
  localparam int F_TS_FILL = 4;
  localparam int F_TX_SHORT = 5;
  localparam int F_TX_LONG = 6;
  localparam int F_RX_LONG = 7;
  localparam int F_TX_OVR = 8;
  localparam int F_RX_UNDR = 9;
  localparam int F_TX_CRC = 10;
  localparam int F_RX_CRC = 11;
  localparam int F_DEAD = 12;
  localparam int F_MAC = 13;
  localparam int F_PHY = 14;
  // reset values
  localparam logic [NFLAG-1:0] FLAGS_RST = 15'h0000;
  localparam logic [LEN_W-1:0] LEN_RST = 12'h000;
  localparam logic [TO_W-1:0] IDLE_RST = 16'h0000;

  typedef logic [NFLAG-1:0] sei_flag_t;

  // kind of fifo transfer now in progress
  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD, ST_RW} sei_xfer_e;

  // fifo levels reported by the fifos
  typedef struct packed {
    logic [FRM_W-1:0] rx_frames;
    logic [RX_LVL_W-1:0] rx_fill;
    logic [TX_LVL_W-1:0] tx_empty;
    logic [TS_LVL_W-1:0] tx_stat_fill;
  } sei_lvl_s;

  // programmed limits
  typedef struct packed {
    logic [FRM_W-1:0] rx_frame_count_limit;
    logic [RX_LVL_W-1:0] rx_fill_limit;
    logic [TO_W-1:0] rx_idle_timeout_limit;
    logic [TX_LVL_W-1:0] tx_space_limit;
    logic [TS_LVL_W-1:0] tx_status_fill_limit;
  } sei_lim_s;

  // decoded command from the serial command engine
  typedef struct packed {
    logic start;
    logic [3:0] code;
    logic [LEN_W-1:0] tx_len;
    logic [LEN_W-1:0] rx_len;
  } sei_cmd_s;
endpackage : sei_pkg

// >>> src/sei_sync.sv
// sei_sync: two-flop synchroniser for pin levels
// assumes inputs are levels from outside the mclk domain
`timescale 1ns/10ps
`default_nettype none
module sei_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1 // levels held in reset
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sei_sync_s;

  sei_sync_s st_r;
  sei_sync_s st_nxt;

  // first stage feeds only the second
  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // register the state; both stages reset to RST_VAL
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : sei_sync
`default_nettype wire

// >>> src/sei_crc16.sv
// sei_crc16: combinational 16-bit crc over a 16-bit length field
// assumes msb-first shifting from the package init value
`timescale 1ns/10ps
`default_nettype none
module sei_crc16 (
  input wire logic [15:0] data, // length field
  output logic [15:0] crc // computed check value
);
  import sei_pkg::*;

  // shift the field through the generator one bit at a time
  always_comb
  begin
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      if (c[15] ^ data[i])
      begin
        c = {c[14:0], 1'b0} ^ CRC_POLY;
      end
      else
      begin
        c = {c[14:0], 1'b0};
      end
    end
    crc = c;
  end
endmodule : sei_crc16
`default_nettype wire

// >>> dv/sei_host_model.sv
// sei_host_model: behavioural serial host, drives select and clock pins
// assumes mode 0 framing; the clock stands low outside frames
`timescale 1ns/10ps
`default_nettype none
module sei_host_model (
  input wire logic go, // frame request, held until busy
  input wire logic [7:0] n_clk, // serial clocks in the frame
  output logic busy, // frame under way
  output logic spi_csn, // chip select, low active
  output logic spi_sck // serial clock, 400 ns period
);
  // one frame: select low, n clocks, select high
  initial
  begin
    busy = 1'b0;
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    forever
    begin
      wait (go);
      busy = 1'b1;
      spi_csn = 1'b0;
      #200;
      repeat (n_clk)
      begin
        spi_sck = 1'b1;
        #200;
        spi_sck = 1'b0;
        #200;
      end
      spi_csn = 1'b1;
      busy = 1'b0;
      wait (!go);
    end
  end
endmodule : sei_host_model
`default_nettype wire

// >>> dv/sei_intr_bench.sv
// sei_intr_bench: raises every event flag, checks pin, mask and clear
// assumes sei_intr and sei_host_model; expectations queued, monitor compares
`timescale 1ns/10ps
`default_nettype none
module sei_intr_bench;
  import sei_pkg::*;
  logic mclk, rst, spi_csn, spi_sck, go, busy, irq_out;
  logic tx_fifo_wr, rx_fifo_rd, tx_flen_vld, rx_flen_vld, stat_deadlock, mac_irq, phy_irq;
  logic [7:0] n_clk;
  logic [31:0] tx_flen_word, rx_flen_word;
  sei_cmd_s cmd;
  sei_lvl_s lvl, lvl0;
  sei_lim_s lim;
  sei_flag_t flag_mask, flag_clr, flag_stat, last_stat, last_mask, nw;
  sei_flag_t exp_q[$];
  int n_fail, n_checks;
  ////////////////////////////////////////////////////////////////////////
  sei_intr i_dut (.mclk(mclk), .rst(rst), .spi_csn(spi_csn), .spi_sck(spi_sck), .cmd(cmd),
    .tx_fifo_wr(tx_fifo_wr), .rx_fifo_rd(rx_fifo_rd), .lvl(lvl), .lim(lim),
    .tx_flen_vld(tx_flen_vld), .tx_flen_word(tx_flen_word), .rx_flen_vld(rx_flen_vld),
    .rx_flen_word(rx_flen_word), .stat_deadlock(stat_deadlock), .mac_irq(mac_irq),
    .phy_irq(phy_irq), .flag_mask(flag_mask), .flag_clr(flag_clr), .flag_stat(flag_stat),
    .irq_out(irq_out));
  sei_host_model i_host (.go(go), .n_clk(n_clk), .busy(busy), .spi_csn(spi_csn),
    .spi_sck(spi_sck));
  ////////////////////////////////////////////////////////////////////////
  // comparisons and closing
  task automatic cmp_flags(input string nm, input sei_flag_t e, input sei_flag_t g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_flags
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // msb-first check value, independent of the design
  function automatic logic [15:0] crc_f(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc_f
  ////////////////////////////////////////////////////////////////////////
  // stimulus helpers, all at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic strobe_wr(input int n);
    repeat (n)
    begin
      tx_fifo_wr <= 1'b1;
      cyc(1);
      tx_fifo_wr <= 1'b0;
      cyc(1);
    end
  endtask : strobe_wr
  task automatic send_cmd(input logic [3:0] c, input logic [LEN_W-1:0] tl,
    input logic [LEN_W-1:0] rl);
    cmd <= '{start: 1'b1, code: c, tx_len: tl, rx_len: rl};
    cyc(1);
    cmd.start <= 1'b0;
    cyc(2);
  endtask : send_cmd
  task automatic frame_start(input logic [7:0] n);
    n_clk <= n;
    go <= 1'b1;
    wait (busy);
    @(negedge mclk);
    go <= 1'b0;
    cyc(5); // select low seen through synchroniser
  endtask : frame_start
  task automatic frame_end();
    int k;
    k = 0;
    while (busy === 1'b1 && k < 400)
    begin
      cyc(1);
      k++;
    end
    if (k == 400)
    begin
      n_fail++;
      $display("[ERR] frame end expected idle seen busy");
    end
    cyc(6);
  endtask : frame_end
  task automatic send_flen(input int b, input logic [31:0] w);
    if (b == F_TX_CRC)
    begin
      tx_flen_word <= w;
      tx_flen_vld <= 1'b1;
    end
    else
    begin
      rx_flen_word <= w;
      rx_flen_vld <= 1'b1;
    end
    cyc(1);
    tx_flen_vld <= 1'b0;
    rx_flen_vld <= 1'b0;
  endtask : send_flen
  task automatic set_lvl(input int b, input int d);
    case (b)
      F_RX_FRM: lvl.rx_frames <= lim.rx_frame_count_limit - FRM_W'(d);
      F_RX_FILL: lvl.rx_fill <= lim.rx_fill_limit - RX_LVL_W'(d);
      F_TX_SPACE: lvl.tx_empty <= lim.tx_space_limit - TX_LVL_W'(d);
      default: lvl.tx_stat_fill <= lim.tx_status_fill_limit - TS_LVL_W'(d);
    endcase
  endtask : set_lvl
  ////////////////////////////////////////////////////////////////////////
  // one flag: cause it, see it raised, hold, clear
  task automatic fire(input int b);
    sei_flag_t bm;
    logic [15:0] ln;
    int to_l, k;
    bm = sei_flag_t'(1) << b;
    ln = 16'($urandom);
    to_l = 6 + $urandom_range(15);
    flag_mask <= sei_flag_t'($urandom);
    cyc(2);
    case (b)
      F_RX_FRM, F_RX_FILL, F_TX_SPACE, F_TS_FILL:
      begin
        set_lvl(b, 1);
        cyc(4);
        exp_q.push_back(bm);
        set_lvl(b, 0);
      end
      F_RX_TO:
      begin
        lim.rx_idle_timeout_limit <= TO_W'(to_l);
        lvl.rx_fill <= 11'h001;
        cyc(to_l - 2);
        rx_fifo_rd <= 1'b1;
        cyc(1);
        rx_fifo_rd <= 1'b0;
        cyc(to_l - 2);
        exp_q.push_back(bm);
      end
      F_TX_SHORT:
      begin
        frame_start(8'h14);
        send_cmd(CMD_FIFO_RW, 12'h001, 12'h000);
        strobe_wr(2);
        cyc(4);
        send_cmd(CMD_TX_WR, 12'h001, 12'h000);
        exp_q.push_back(bm);
        // one strobe leaves the extra serial clocks to raise the flag
        strobe_wr(1 + $urandom_range(1));
        frame_end();
      end
      F_TX_LONG, F_RX_LONG:
      begin
        frame_start(8'h04);
        if (b == F_TX_LONG)
          send_cmd(CMD_TX_WR, 12'h002 + 12'($urandom_range(4093)), 12'h000);
        else
          send_cmd(CMD_RX_RD, 12'h000, 12'h001 + 12'($urandom_range(4094)));
        strobe_wr(b == F_TX_LONG ? 1 : 0);
        exp_q.push_back(bm);
        frame_end();
      end
      F_TX_OVR:
      begin
        lvl.tx_empty <= 10'h000;
        cyc(1);
        exp_q.push_back(bm);
        strobe_wr(1);
      end
      F_RX_UNDR:
      begin
        exp_q.push_back(bm);
        rx_fifo_rd <= 1'b1;
        cyc(1);
        rx_fifo_rd <= 1'b0;
      end
      F_TX_CRC, F_RX_CRC:
      begin
        send_flen(b, {crc_f(ln), ln});
        cyc(4);
        exp_q.push_back(bm);
        send_flen(b, {crc_f(ln) ^ (16'h0001 << ln[3:0]), ln});
      end
      F_DEAD:
      begin
        exp_q.push_back(bm);
        stat_deadlock <= 1'b1;
        cyc(1);
        stat_deadlock <= 1'b0;
      end
      default:
      begin
        exp_q.push_back(bm);
        if (b == F_MAC)
          mac_irq <= 1'b1;
        else
          phy_irq <= 1'b1;
      end
    endcase
    k = 0;
    while (exp_q.size() != 0 && k < 300)
    begin
      cyc(1);
      k++;
    end
    if (exp_q.size() != 0)
    begin
      n_fail++;
      $display("[ERR] flag %0d expected raised seen quiet", b);
      exp_q.delete();
    end
    if (b == F_MAC)
    begin
      flag_clr <= bm;
      cyc(1);
      flag_clr <= '0;
      cyc(2);
      cmp_flags("set over clear", bm, flag_stat);
    end
    lvl <= lvl0;
    lim.rx_idle_timeout_limit <= 16'hffff;
    mac_irq <= 1'b0;
    phy_irq <= 1'b0;
    cyc(3);
    cmp_flags("pending", bm, flag_stat);
    flag_clr <= bm;
    cyc(1);
    flag_clr <= '0;
    cyc(2);
    cmp_flags("cleared", '0, flag_stat);
  endtask : fire
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // monitor: new flags against the oldest note, pin against mask
  always @(negedge mclk)
  begin
    if (rst === 1'b0)
    begin
      nw = flag_stat & ~last_stat;
      if (nw !== '0)
      begin
        if (exp_q.size() == 0)
          cmp_flags("unexpected flags", '0, nw);
        else
          cmp_flags("raised flags", exp_q.pop_front(), nw);
      end
      if (flag_mask === last_mask)
        cmp_bit("irq_out", |(flag_stat & ~flag_mask), irq_out);
    end
    last_stat = flag_stat;
    last_mask = flag_mask;
  end
  // watchdog
  initial
  begin
    #(50 * 30000);
    n_fail++;
    $display("[ERR] watchdog expected done seen running");
    summarize();
  end
  // main sequence
  initial
  begin
    void'($urandom(68));
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    go = 1'b0;
    n_clk = 8'h00;
    cmd = '0;
    tx_fifo_wr = 1'b0;
    rx_fifo_rd = 1'b0;
    lvl0 = '0;
    lvl0.tx_empty = 10'h005;
    lvl = lvl0;
    lim = '{rx_frame_count_limit: 8'h01, rx_fill_limit: 11'h200, rx_idle_timeout_limit: 16'hffff,
      tx_space_limit: 10'h200, tx_status_fill_limit: 6'h01 + 6'($urandom_range(62))};
    tx_flen_vld = 1'b0;
    rx_flen_vld = 1'b0;
    tx_flen_word = '0;
    rx_flen_word = '0;
    stat_deadlock = 1'b0;
    mac_irq = 1'b0;
    phy_irq = 1'b0;
    flag_mask = '0;
    flag_clr = '0;
    last_stat = '0;
    last_mask = '0;
    cyc(5);
    rst <= 1'b0;
    cyc(4);
    repeat (2)
      for (int b = 0; b < NFLAG; b++)
        fire(b);
    summarize();
  end
endmodule : sei_intr_bench
`default_nettype wire
